// ---- src/dual_channel_fault_status_irq.sv ----
// Two read-only status registers of a dual supply regulator and the
// active-low interrupt they drive. Assumes the serial engine gives a
// same-clock read strobe with a select and a read-complete pulse, and
// that comparator inputs are asynchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none

`include "fault_status_params.svh"

module dual_channel_fault_status_irq
  import fault_status_pkg::*;
#(
  parameter int   RETRY_CYCLES  = `US_TO_CYCLES(`RETRY_TIME_US),
  parameter int   DELAY1_CYCLES = `US_TO_CYCLES(`EPF_DELAY1_US),
  parameter int   DELAY2_CYCLES = `US_TO_CYCLES(`EPF_DELAY2_US),
  parameter int   DELAY3_CYCLES = `US_TO_CYCLES(`EPF_DELAY3_US),
  parameter logic FACTORY_LOCK  = 1'b1   // Arbitrary value
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Register read port from the serial engine
  input  wire logic       rd_strobe,
  input  wire logic [7:0] register_select,
  input  wire logic       read_done,
  output logic      [7:0] rd_data,
  // Control bits held elsewhere
  input  wire logic [1:0] ch_enable,
  input  wire logic       restart_policy,
  input  wire logic       power_fail_delay_lsb,
  input  wire logic       power_fail_delay_msb,
  // Comparator inputs, asynchronous
  input  wire logic [1:0] ch_overcurrent_in,
  input  wire logic       overtemperature_in,
  input  wire logic       supply_undervoltage_in,
  input  wire logic       supply_above_9v_in,
  input  wire logic [1:0] ch_voltage_bad_in,
  input  wire logic [1:0] ch_pump_good_in,
  input  wire logic [1:0] ch_tone_seen_in,
  input  wire logic [1:0] ch_boost_high_in,
  input  wire logic       power_fail_in,
  // Results
  output logic      [1:0] ch_output_on,
  output logic            irq_n
);

  localparam int RW = $clog2(RETRY_CYCLES);
  localparam int SW = 14;

  // Refuse a retry period the counter cannot serve
  if (RETRY_CYCLES < 2) begin : g_chk
    $error("dual_channel_fault_status_irq: RETRY_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // Asserts at once, releases after two edges
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  wire  logic [SW-1:0] raw_in = {power_fail_in, ch_boost_high_in, ch_tone_seen_in, ch_pump_good_in,
                                 ch_voltage_bad_in, supply_above_9v_in, supply_undervoltage_in,
                                 overtemperature_in, ch_overcurrent_in};
  logic       [SW-1:0] meta_q;
  logic       [SW-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  wire logic [1:0] oc_now     = sync_q[1:0];
  wire logic       ot_now     = sync_q[2];
  wire logic       uv_now     = sync_q[3];
  wire logic       vin_ok     = sync_q[4];
  wire logic [1:0] vbad_now   = sync_q[6:5];
  wire logic [1:0] pump_now   = sync_q[8:7];
  wire logic [1:0] tone_now   = sync_q[10:9];
  wire logic [1:0] boost_now  = sync_q[12:11];
  wire logic       pfail_now  = sync_q[13];

  // ----------------------------------------------------------------
  // Auto-retry tick
  // ----------------------------------------------------------------
  logic [RW-1:0] retry_cnt_q;
  wire  logic    retry_tick = (retry_cnt_q == RW'(RETRY_CYCLES - 1));

  // Free-running 1 s period; a flag may wait up to one full period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      retry_cnt_q <= '0;
    end else begin
      retry_cnt_q <= retry_tick ? '0 : retry_cnt_q + RW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Latched faults
  // ----------------------------------------------------------------
  // Clear chances: periodic retry or a completed host read
  wire logic retry_clear = restart_policy && retry_tick;
  wire logic read_clear  = !restart_policy && read_done;

  logic [1:0] oc_q;
  logic [1:0] oc_d;
  logic       ot_q;
  logic       ot_d;
  logic       uv_q;
  logic       uv_d;
  logic [1:0] off_q;
  logic [1:0] off_d;
  logic [1:0] ch_fault;

  // Live condition re-sets the flag, so the set wins over any clear
  assign ot_d = ot_now || (ot_q && !(retry_clear || read_clear));
  assign uv_d = uv_now || (uv_q && !(read_done && vin_ok));

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      assign oc_d[ch]     = oc_now[ch] || (oc_q[ch] && !(retry_clear || read_clear));
      assign ch_fault[ch] = oc_q[ch] || oc_now[ch] || ot_q || uv_q || !pump_now[ch];
      // Off holds until enabled and nothing is wrong
      assign off_d[ch]    = (!ch_enable[ch] || ch_fault[ch]) ? 1'b1 : 1'b0;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_q  <= {2{`FLAG_RESET}};
      ot_q  <= `FLAG_RESET;
      uv_q  <= `FLAG_RESET;
      off_q <= {2{`OUTPUT_OFF_RESET}};
    end else begin
      oc_q  <= oc_d;
      ot_q  <= ot_d;
      uv_q  <= uv_d;
      off_q <= off_d;
    end
  end

  assign ch_output_on = ~off_q;

  // ----------------------------------------------------------------
  // Early power fail warning
  // ----------------------------------------------------------------
  epf_link_if epf_link ();

  assign epf_link.supply_low = pfail_now;
  assign epf_link.delay_sel  = {power_fail_delay_msb, power_fail_delay_lsb};
  assign epf_link.read_done  = read_done;

  epf_hold #(
    .DELAY1_CYCLES (DELAY1_CYCLES),
    .DELAY2_CYCLES (DELAY2_CYCLES),
    .DELAY3_CYCLES (DELAY3_CYCLES)
  ) u_epf_hold (
    .clk   (core_clk),
    .rst_n (rst_n),
    .link  (epf_link.timer)
  );

  // ----------------------------------------------------------------
  // Status images
  // ----------------------------------------------------------------
  logic [7:0] primary_img;
  logic [7:0] secondary_img;

  always_comb begin
    primary_img                          = 8'h00;
    primary_img[`BIT_CH1_OUTPUT_OFF]     = off_q[0];
    primary_img[`BIT_CH2_OUTPUT_OFF]     = off_q[1];
    primary_img[`BIT_CH1_OVERCURRENT]    = oc_q[0];
    primary_img[`BIT_CH2_OVERCURRENT]    = oc_q[1];
    primary_img[`BIT_CH1_VOLTAGE_BAD]    = vbad_now[0];
    primary_img[`BIT_CH2_VOLTAGE_BAD]    = vbad_now[1];
    primary_img[`BIT_SUPPLY_UNDERVOLT]   = uv_q;
    primary_img[`BIT_OVERTEMPERATURE]    = ot_q;
  end

  always_comb begin
    secondary_img                        = 8'h00;
    secondary_img[`BIT_CH1_PUMP_GOOD]    = pump_now[0];
    secondary_img[`BIT_CH2_PUMP_GOOD]    = pump_now[1];
    secondary_img[`BIT_CH1_TONE_SEEN]    = tone_now[0];
    secondary_img[`BIT_CH2_TONE_SEEN]    = tone_now[1];
    secondary_img[`BIT_EARLY_POWER_FAIL] = epf_link.warn;
    secondary_img[`BIT_FACTORY_LOCK]     = FACTORY_LOCK;
    secondary_img[`BIT_CH1_BOOST_HIGH]   = boost_now[0];
    secondary_img[`BIT_CH2_BOOST_HIGH]   = boost_now[1];
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  wire logic sel_primary   = (register_select == `FAULT_STATUS_PRIMARY_ADDR);
  wire logic sel_secondary = (register_select == `MONITOR_STATUS_SECONDARY_ADDR);
  wire logic [7:0] rd_mux  = sel_primary   ? primary_img   :
                             sel_secondary ? secondary_img : `STATUS_UNMAPPED_VALUE;

  // Snapshot on strobe so the serializer sees a stable byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_strobe) begin
      rd_data <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // Only these four sources may pull the line
  wire logic irq_any = (|oc_q) || ot_q || uv_q || epf_link.irq_pending;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !irq_any;
    end
  end

endmodule

`default_nettype wire

// ---- src/fault_status_params.svh ----
// Constants for the dual-channel fault status and interrupt block.
// Assumes a single 10 MHz core clock; included by bare name.
`ifndef FAULT_STATUS_PARAMS_SVH
`define FAULT_STATUS_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define FAULT_STATUS_PRIMARY_ADDR     8'h00
`define MONITOR_STATUS_SECONDARY_ADDR 8'h01
`define STATUS_UNMAPPED_VALUE         8'h00

// ----------------------------------------------------------------
// Field positions, register 0
// ----------------------------------------------------------------
`define BIT_CH1_OUTPUT_OFF    0
`define BIT_CH2_OUTPUT_OFF    1
`define BIT_CH1_OVERCURRENT   2
`define BIT_CH2_OVERCURRENT   3
`define BIT_CH1_VOLTAGE_BAD   4
`define BIT_CH2_VOLTAGE_BAD   5
`define BIT_SUPPLY_UNDERVOLT  6
`define BIT_OVERTEMPERATURE   7

// ----------------------------------------------------------------
// Field positions, register 1
// ----------------------------------------------------------------
`define BIT_CH1_PUMP_GOOD     0
`define BIT_CH2_PUMP_GOOD     1
`define BIT_CH1_TONE_SEEN     2
`define BIT_CH2_TONE_SEEN     3
`define BIT_EARLY_POWER_FAIL  4
`define BIT_FACTORY_LOCK      5
`define BIT_CH1_BOOST_HIGH    6
`define BIT_CH2_BOOST_HIGH    7

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define FLAG_RESET            1'b0
`define OUTPUT_OFF_RESET      1'b1
`define CLK_FREQ_HZ           10000000
`define RETRY_TIME_US         1000000
`define EPF_DELAY1_US         11500
`define EPF_DELAY2_US         46000
`define EPF_DELAY3_US         92000
// Whole-microsecond scaling keeps 11.5 ms exact at this clock
`define US_TO_CYCLES(t)       ((t) * (`CLK_FREQ_HZ / 1000000))

`endif

// ---- src/fault_status_pkg.sv ----
// Types shared by the fault status block and its power-fail timer.
// Holds no constants; those live in the params header.
`default_nettype none

package fault_status_pkg;

  // Early power fail warning sequence
  typedef enum logic [1:0] {
    EPF_IDLE,
    EPF_ACTIVE,
    EPF_HOLD
  } epf_state_t;

endpackage

`default_nettype wire

// ---- src/epf_link_if.sv ----
// Carries the early power fail signals between the status core and its timer.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
`default_nettype none

interface epf_link_if;
  logic       supply_low;     // Synced comparator, high while below threshold
  logic [1:0] delay_sel;      // {power_fail_delay_msb, power_fail_delay_lsb}
  logic       read_done;      // Host read sequence completed
  logic       warn;           // Status bit value
  logic       irq_pending;    // Interrupt request held for this warning

  modport core  (output supply_low, output delay_sel, output read_done,
                 input warn, input irq_pending);
  modport timer (input supply_low, input delay_sel, input read_done,
                 output warn, output irq_pending);
endinterface

`default_nettype wire

// ---- src/epf_hold.sv ----
// Early power fail warning with a programmable release delay.
// Assumes synchronised inputs and the synchronised reset of the core.
`timescale 1ns/100ps
`default_nettype none

`include "fault_status_params.svh"

module epf_hold
  import fault_status_pkg::*;
#(
  parameter int DELAY1_CYCLES = `US_TO_CYCLES(`EPF_DELAY1_US),
  parameter int DELAY2_CYCLES = `US_TO_CYCLES(`EPF_DELAY2_US),
  parameter int DELAY3_CYCLES = `US_TO_CYCLES(`EPF_DELAY3_US)
) (
  input  wire logic     clk,
  input  wire logic     rst_n,
  epf_link_if.timer     link
);

  localparam int CW = $clog2(DELAY3_CYCLES + 1);

  // Refuse delays the counter cannot order or hold
  if (DELAY1_CYCLES < 1 || DELAY2_CYCLES < DELAY1_CYCLES || DELAY3_CYCLES < DELAY2_CYCLES) begin : g_chk
    $error("epf_hold: delay counts must be positive and ascending");
  end

  // ----------------------------------------------------------------
  // Delay decode
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] hold_limit(input logic [1:0] sel);
    case (sel)
      2'h1:    hold_limit = CW'(DELAY1_CYCLES);
      2'h2:    hold_limit = CW'(DELAY2_CYCLES);
      2'h3:    hold_limit = CW'(DELAY3_CYCLES);
      default: hold_limit = '0;
    endcase
  endfunction

  epf_state_t    state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          irq_q, irq_d;
  wire  logic    hold_over = (cnt_q >= hold_limit(link.delay_sel));

  // Warning stays up through the hold time; zero delay drops at once
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      EPF_IDLE: begin
        if (link.supply_low) begin
          state_d = EPF_ACTIVE;
        end
      end
      EPF_ACTIVE: begin
        cnt_d = '0;
        if (!link.supply_low) begin
          state_d = (hold_limit(link.delay_sel) == '0) ? EPF_IDLE : EPF_HOLD;
        end
      end
      EPF_HOLD: begin
        cnt_d = cnt_q + CW'(1);
        if (link.supply_low) begin
          state_d = EPF_ACTIVE;
        end else if (hold_over) begin
          state_d = EPF_IDLE;
        end
      end
      default: state_d = EPF_IDLE;
    endcase
  end

  // Interrupt holds until read; a new warning in the read cycle wins
  assign irq_d = (link.supply_low && state_q == EPF_IDLE) || (irq_q && !link.read_done);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= EPF_IDLE;
      cnt_q   <= '0;
      irq_q   <= `FLAG_RESET;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      irq_q   <= irq_d;
    end
  end

  assign link.warn        = (state_q != EPF_IDLE);
  assign link.irq_pending = irq_q;

endmodule

`default_nettype wire

// ---- verif/fault_status_chk.sv ----
// Assertions on the status block's top ports.
// Assumes one core clock and the active-low reset resetn.
`timescale 1ns/100ps
`default_nettype none

module fault_status_chk #(
  parameter int   RETRY_CYCLES = 50,
  parameter logic FACTORY_LOCK = 1'b1
) (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       rd_strobe,
  input wire logic [7:0] register_select,
  input wire logic       read_done,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] ch_enable,
  input wire logic       restart_policy,
  input wire logic [1:0] ch_overcurrent_in,
  input wire logic       overtemperature_in,
  input wire logic       supply_undervoltage_in,
  input wire logic       supply_above_9v_in,
  input wire logic [1:0] ch_voltage_bad_in,
  input wire logic [1:0] ch_pump_good_in,
  input wire logic [1:0] ch_tone_seen_in,
  input wire logic [1:0] ch_boost_high_in,
  input wire logic       power_fail_in,
  input wire logic [1:0] ch_output_on,
  input wire logic       irq_n
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  int unsigned cool_q;
  logic        rd0;
  logic        rd1;
  assign rd0 = rd_strobe && register_select == 8'h00;
  assign rd1 = rd_strobe && register_select == 8'h01;

  // Cycles spent in retry mode without overtemperature, saturating
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) cool_q <= 0;
    else if (!restart_policy || overtemperature_in) cool_q <= 0;
    else if (cool_q < RETRY_CYCLES + 8) cool_q <= cool_q + 1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Nothing can hold the interrupt once these have been quiet a while
  sequence s_quiet;
    (ch_overcurrent_in == 2'b00 && !overtemperature_in && !supply_undervoltage_in
     && supply_above_9v_in && !power_fail_in && !restart_policy) [*4];
  endsequence
  sequence s_live1;
    $stable({ch_boost_high_in, ch_tone_seen_in, ch_pump_good_in}) [*5];
  endsequence

  property p_unmapped;
    rd_strobe && register_select > 8'h01 |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_lock;
    rd1 |=> rd_data[5] == FACTORY_LOCK;
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit changed");
  property p_live0;
    $stable(ch_voltage_bad_in) [*5] ##0 rd0 |=> rd_data[5:4] == $past(ch_voltage_bad_in);
  endproperty
  a_live0: assert property (p_live0) else $error("voltage bad bits wrong");
  property p_live1;
    s_live1 ##0 rd1 |=> {rd_data[7:6], rd_data[3:0]}
      == $past({ch_boost_high_in, ch_tone_seen_in, ch_pump_good_in});
  endproperty
  a_live1: assert property (p_live1) else $error("live monitor bits wrong");
  property p_ot_retry;
    rd0 && cool_q > RETRY_CYCLES + 5 |=> !rd_data[7];
  endproperty
  a_ot_retry: assert property (p_ot_retry) else $error("overtemp not retried");
  property p_oc_irq;
    ch_overcurrent_in[0] [*8] |=> !irq_n;
  endproperty
  a_oc_irq: assert property (p_oc_irq) else $error("overcurrent without irq");
  property p_ot_irq;
    overtemperature_in [*8] |=> !irq_n;
  endproperty
  a_ot_irq: assert property (p_ot_irq) else $error("overtemp without irq");
  property p_uv_irq;
    supply_undervoltage_in [*8] |=> !irq_n;
  endproperty
  a_uv_irq: assert property (p_uv_irq) else $error("undervoltage without irq");
  property p_irq_clear;
    s_quiet ##0 read_done |-> ##2 irq_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not released");
  property p_irq_hold;
    !irq_n && !read_done && !$past(read_done) && !restart_policy
      && !$past(restart_policy) |=> !irq_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq released without read");
  property p_off_dis;
    !ch_enable[0] [*3] |-> !ch_output_on[0];
  endproperty
  a_off_dis: assert property (p_off_dis) else $error("disabled channel runs");
  property p_oc_off;
    ch_overcurrent_in[1] [*6] |-> !ch_output_on[1];
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("overcurrent channel runs");
endmodule

bind dual_channel_fault_status_irq fault_status_chk #(
  .RETRY_CYCLES(RETRY_CYCLES), .FACTORY_LOCK(FACTORY_LOCK)) u_chk (
  .core_clk, .resetn, .rd_strobe, .register_select, .read_done, .rd_data, .ch_enable,
  .restart_policy, .ch_overcurrent_in, .overtemperature_in, .supply_undervoltage_in,
  .supply_above_9v_in, .ch_voltage_bad_in, .ch_pump_good_in, .ch_tone_seen_in,
  .ch_boost_high_in, .power_fail_in, .ch_output_on, .irq_n);

`default_nettype wire

// ---- verif/serial_host_model.sv ----
// Serial host model: register reads and read-complete marks.
// Assumes the same clock as the status block.
`timescale 1ns/100ps
`default_nettype none

module serial_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            rd_strobe,
  output logic      [7:0] register_select,
  output logic            read_done
);
  initial begin
    rd_strobe = 1'b0;
    register_select = 8'h5a;
    read_done = 1'b0;
  end

  // One read; a random idle gap makes the host prompt or slow
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    repeat ($urandom_range(1)) @(posedge clk);
    @(posedge clk);
    rd_strobe <= 1'b1;
    register_select <= a;
    @(posedge clk);
    rd_strobe <= 1'b0;
    register_select <= ~a; // Idle select never shows the last address
    @(negedge clk);
    d = rd_data;
  endtask

  // Completed read sequence, one pulse
  task automatic finish();
    @(posedge clk);
    read_done <= 1'b1;
    @(posedge clk);
    read_done <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- verif/test_dual_channel_fault_status_irq.sv ----
// Self-checking bench for the fault status block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none

module test_dual_channel_fault_status_irq;
  localparam int   RETRY = 50;
  localparam logic LOCK  = 1'b1; // Arbitrary
  int         dly[4] = '{0, 8, 16, 32};
  logic       core_clk, resetn, rd_strobe, read_done, restart_policy, irq_n;
  logic       power_fail_delay_lsb, power_fail_delay_msb, power_fail_in;
  logic       overtemperature_in, supply_undervoltage_in, supply_above_9v_in;
  logic [7:0] register_select, rd_data;
  logic [1:0] ch_enable, ch_overcurrent_in, ch_voltage_bad_in, ch_pump_good_in;
  logic [1:0] ch_tone_seen_in, ch_boost_high_in, ch_output_on;
  logic [2:0] m_f;
  logic       m_uv, m_ew, m_ep;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  dual_channel_fault_status_irq #(.RETRY_CYCLES(RETRY), .DELAY1_CYCLES(8), .DELAY2_CYCLES(16),
    .DELAY3_CYCLES(32), .FACTORY_LOCK(LOCK)) DUT (
    .core_clk, .resetn, .rd_strobe, .register_select, .read_done, .rd_data, .ch_enable,
    .restart_policy, .power_fail_delay_lsb, .power_fail_delay_msb, .ch_overcurrent_in,
    .overtemperature_in, .supply_undervoltage_in, .supply_above_9v_in, .ch_voltage_bad_in,
    .ch_pump_good_in, .ch_tone_seen_in, .ch_boost_high_in, .power_fail_in, .ch_output_on, .irq_n);
  serial_host_model host (.clk(core_clk), .rd_data, .rd_strobe, .register_select, .read_done);

  // ------------------------------------------------------------
  // Reference model and checks
  // ------------------------------------------------------------
  function automatic logic [7:0] exp0();
    logic [1:0] off;
    for (int i = 0; i < 2; i++) off[i] = !ch_enable[i] | m_f[i] | ch_overcurrent_in[i]
      | m_f[2] | m_uv | !ch_pump_good_in[i];
    return {m_f[2], m_uv, ch_voltage_bad_in, m_f[1:0], off};
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk();
    logic [7:0] d;
    logic [7:0] e;
    e = exp0();
    host.rd(8'h00, d);
    cmp(d, e, "status0");
    host.rd(8'h01, d);
    cmp(d, {ch_boost_high_in, LOCK, m_ew, ch_tone_seen_in, ch_pump_good_in}, "status1");
    cmp({7'h00, irq_n}, {7'h00, !(|m_f || m_uv || m_ep)}, "irq_n");
    cmp({6'h00, ch_output_on}, {6'h00, ~e[1:0]}, "output on");
  endtask

  // Completed read: fault flags drop only where their cause is gone; the power fail interrupt always drops
  task automatic done();
    host.finish();
    if (!restart_policy) m_f &= {overtemperature_in, ch_overcurrent_in};
    if (!supply_undervoltage_in && supply_above_9v_in) m_uv = 1'b0;
    m_ep = 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic settle();
    repeat (5) @(posedge core_clk);
  endtask

  task automatic src(input int k, input logic v);
    @(posedge core_clk);
    if (k < 2) ch_overcurrent_in[k] <= v;
    else overtemperature_in <= v;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, timeout, stimulus
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Cuts a hang short well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: timeout", $time);
      close_out();
    end
  end

  initial begin
    logic [7:0] d;
    resetn = 1'b0;
    ch_enable = 2'b00;
    restart_policy = 1'b0;
    {power_fail_delay_msb, power_fail_delay_lsb} = 2'b00;
    {ch_overcurrent_in, overtemperature_in, supply_undervoltage_in, power_fail_in} = 5'h00;
    supply_above_9v_in = 1'b1;
    {ch_voltage_bad_in, ch_tone_seen_in, ch_boost_high_in} = 6'h00;
    ch_pump_good_in = 2'b11;
    {m_f, m_uv, m_ew, m_ep} = 6'h00;
    void'($urandom(32'h94c2));
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk();
    host.rd(8'h02, d);
    cmp(d, 8'h00, "unmapped");
    @(posedge core_clk) ch_enable <= 2'b11;
    settle();
    chk();
    repeat (8) begin
      @(posedge core_clk);
      {ch_boost_high_in, ch_tone_seen_in, ch_pump_good_in, ch_voltage_bad_in} <= 8'($urandom);
      settle();
      chk();
    end
    @(posedge core_clk) ch_pump_good_in <= 2'b11;
    settle();
    chk();
    // Latched faults, read while present then after removal
    for (int k = 0; k < 3; k++) begin
      src(k, 1'b1);
      m_f[k] = 1'b1;
      settle();
      done();
      chk();
      src(k, 1'b0);
      settle();
      chk();
      done();
      chk();
    end
    @(posedge core_clk);
    supply_undervoltage_in <= 1'b1;
    supply_above_9v_in <= 1'b0;
    m_uv = 1'b1;
    settle();
    chk();
    @(posedge core_clk) supply_undervoltage_in <= 1'b0;
    settle();
    done();
    chk();
    @(posedge core_clk) supply_above_9v_in <= 1'b1;
    settle();
    done();
    chk();
    // Auto-retry: held while present, cleared by the tick once gone
    @(posedge core_clk) restart_policy <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      src(k, 1'b1);
      m_f[k] = 1'b1;
      repeat (2 * RETRY) @(posedge core_clk);
      chk();
      src(k, 1'b0);
      repeat (RETRY + 10) @(posedge core_clk);
      m_f[k] = 1'b0;
      chk();
    end
    @(posedge core_clk) restart_policy <= 1'b0;
    // Power fail warning with each release delay
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      {power_fail_delay_msb, power_fail_delay_lsb} <= 2'(s);
      power_fail_in <= 1'b1;
      m_ew = 1'b1;
      m_ep = 1'b1;
      settle();
      chk();
      @(posedge core_clk) power_fail_in <= 1'b0;
      if (s > 0) begin
        repeat (dly[s] - 4) @(posedge core_clk);
        host.rd(8'h01, d);
        cmp(d[4], m_ew, "warning held");
      end
      repeat (12) @(posedge core_clk);
      m_ew = 1'b0;
      chk();
      done();
      chk();
    end
    close_out();
  end
endmodule

`default_nettype wire
